/* File: bench/prioritized_vectored_irq_unit_bench.sv */
// Self-checking bench of the interrupt unit
`timescale 1ns/1ps
`default_nettype none
module prioritized_vectored_irq_unit_bench;
   logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
   logic ien = 0, idis = 0, software_break = 0, do_ret = 0, pld, hold, wd_rst;
   logic [7:0] adr = 0, q, sp, status, sa, sd, sr;
   logic [31:0] wd = 0, rdat, seed = 32'd54431;
   logic [3:0] pins = 0;
   logic [11:0] ev = 0;
   logic [15:0] pc_in, pc_out, va, saved;
   logic [7:0] vd;
   logic ack, idone, iret, sdec, sinc, swe, srd, vrd;
   int n_mismatch = 0, num_checks = 0, n_load = 0, hcnt = 0, a, b;
   int n_wdr = 0;
   always #4 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      n_load <= n_load + (pld === 1'b1 ? 1 : 0);
      hcnt <= (hold === 1'b1) ? hcnt + 1 : 0;
      n_wdr <= n_wdr + (wd_rst === 1'b1 ? 1 : 0);
   end
   pvi_irq_unit u_pvi_irq_unit (.clk_i(clk_i), .rst_i(rst_i),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(4'hf), .wb_dat_i(wd), .wb_dat_o(rdat), .wb_ack_o(ack),
      .ext_irq_pin_i(pins), .timer_match_i({ev[7:6], ev[3:2]}),
      .conv_done_i(ev[8]), .watchdog_match_i(ev[9]),
      .interval_ovf_i(ev[10]), .serial_req_i(ev[11]),
      .watchdog_reset_o(wd_rst), .instr_done_i(idone),
      .irq_return_instr_i(iret), .irq_enable_instr_i(ien),
      .irq_disable_instr_i(idis), .software_break_i(software_break), .pc_i(pc_in),
      .sp_i(sp), .hold_o(hold), .pc_o(pc_out), .pc_load_o(pld),
      .sp_dec_o(sdec), .sp_inc_o(sinc), .stk_we_o(swe), .stk_rd_o(srd),
      .stk_addr_o(sa), .stk_wdata_o(sd), .stk_rdata_i(sr), .vec_rd_o(vrd),
      .vec_addr_o(va), .vec_data_i(vd), .status_o(status));
   pvi_core_model u_core (.clk_i(clk_i), .rst_i(rst_i), .hold_i(hold),
      .do_ret_i(do_ret), .pc_new_i(pc_out), .pc_load_i(pld),
      .sp_dec_i(sdec), .sp_inc_i(sinc), .stk_we_i(swe), .stk_rd_i(srd),
      .stk_addr_i(sa), .stk_wdata_i(sd), .vec_rd_i(vrd), .vec_addr_i(va),
      .instr_done_o(idone), .ret_o(iret), .pc_o(pc_in), .sp_o(sp),
      .stk_rdata_o(sr), .vec_data_o(vd));
   // =====================================================
   // Helpers
   function automatic logic [15:0] exp_pc(input logic [15:0] v);
      logic [15:0] h;
      h = v + 16'h0001;
      return {h[7:0] ^ 8'h3c, v[7:0] ^ 8'h3c};
   endfunction
   function automatic logic [15:0] vec(input int i);
      return 16'hfffa - 16'(2 * i);
   endfunction
   function automatic int xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return int'(seed % 32'd12);
   endfunction
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic stuck;
      n_mismatch++;
      $display("ERROR at %0t: wait timed out", $time);
      test_done;
   endtask
   // Classic single cycle; ack is sampled at the edge, never assumed
   task automatic wb(input logic w, input logic [7:0] x, input logic [7:0] d);
      int k;
      @(posedge clk_i);
      cyc <= 1; stb <= 1; we <= w; adr <= x; wd <= {24'h0, d};
      k = 0;
      do begin @(posedge clk_i); k++; end while (ack !== 1'b1 && k < 50);
      if (k >= 50) stuck;
      q = rdat[7:0];
      cyc <= 0; stb <= 0;
   endtask
   task automatic wait_load;
      int k;
      k = 0;
      do begin @(posedge clk_i); k++; end while (pld !== 1'b1 && k < 400);
      if (k >= 400) stuck;
   endtask
   task automatic fire(input int i);
      @(posedge clk_i);
      if (i == 0 || i == 1 || i == 4 || i == 5) begin
         pins[i < 2 ? i : i - 2] <= ~pins[i < 2 ? i : i - 2];
      end else ev[i] <= 1'b1;
      @(posedge clk_i);
      ev <= '0;
   endtask
   task automatic pulse(input logic en);
      @(posedge clk_i);
      if (en) ien <= 1'b1; else idis <= 1'b1;
      @(posedge clk_i);
      ien <= 1'b0; idis <= 1'b0;
   endtask
   // Accept, check pushes, then return and check the restore
   task automatic serve(input logic [15:0] v, input logic [7:0] psw,
                        input int i);
      wait_load;
      software_break <= 1'b0;
      check(pc_out, exp_pc(v));
      check(16'(hcnt), 16'd7);
      check({15'd0, status[2]}, 16'd0);
      check({u_core.mem[8'hff], u_core.mem[8'hfe]}, u_core.last_pc);
      check({u_core.mem[8'hfd], sp}, {psw, 8'hfc});
      saved = u_core.last_pc;
      if (i >= 0) begin
         wb(0, i < 8 ? 8'he4 : 8'he5, 8'h00);
         check({15'd0, q[i < 8 ? 7 - i : 15 - i]}, 16'd0);
      end
      do_ret <= 1'b1;
      wait_load;
      do_ret <= 1'b0;
      check(pc_out, saved);
      check({8'h00, status}, {8'h00, psw});
   endtask
   // =====================================================
   // Sequence
   initial begin
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      wait_load;
      check(pc_out, exp_pc(16'hfffe));
      wb(1, 8'he6, 8'hff);
      wb(0, 8'he6, 8'h00);
      check({8'h00, q}, 16'h00ff);
      wb(1, 8'he2, 8'hff);
      wb(1, 8'he3, 8'hf0);
      wb(0, 8'h10, 8'h00);
      check({8'h00, q}, 16'h0000);
      $display("test setup done");
      for (int i = 0; i < 12; i++) begin
         pulse(1);
         fire(i);
         serve(vec(i), 8'h00, i);
      end
      $display("test sources done");
      wb(1, 8'he2, 8'h7f);
      fire(0);
      pulse(1);
      a = n_load;
      repeat (40) @(posedge clk_i);
      check(16'(n_load), 16'(a));
      wb(0, 8'he4, 8'h00);
      check({15'd0, q[7]}, 16'd1);
      pulse(0);
      wb(1, 8'he4, 8'h00);
      wb(1, 8'he2, 8'hff);
      wb(1, 8'he5, 8'h1f);
      wb(0, 8'he5, 8'h00);
      check({8'h00, q}, 16'h0010);
      wb(1, 8'he5, 8'h00);
      wb(1, 8'he8, 8'h01);
      fire(9);
      wb(0, 8'he5, 8'h00);
      check({15'd0, q[6]}, 16'd0);
      check(16'(n_wdr), 16'd1);
      wb(1, 8'he8, 8'h00);
      // Pin 0 falling only: the rising toggle must leave no flag
      wb(1, 8'he6, 8'h01);
      fire(0);
      repeat (8) @(posedge clk_i);
      wb(0, 8'he4, 8'h00);
      check({15'd0, q[7]}, 16'd0);
      fire(0);
      repeat (8) @(posedge clk_i);
      wb(0, 8'he4, 8'h00);
      check({15'd0, q[7]}, 16'd1);
      wb(1, 8'he4, 8'h00);
      wb(1, 8'he6, 8'hff);
      $display("test gating done");
      // Two pending while masked: the higher one must go first
      repeat (6) begin
         a = xs();
         b = xs();
         if (a == b) b = (a + 1) % 12;
         fire(a);
         fire(b);
         repeat (8) @(posedge clk_i);
         check({15'd0, status[2]}, 16'd0);
         pulse(1);
         serve(vec(a < b ? a : b), 8'h00, -1);
         // Stacked status holds the cleared master flag
         pulse(1);
         serve(vec(a < b ? b : a), 8'h00, -1);
         pulse(0);
      end
      $display("test priority done");
      @(posedge clk_i);
      software_break <= 1'b1;
      serve(16'hffde, 8'h00, -1);
      $display("test break done");
      test_done;
   end
endmodule
`default_nettype wire

/* File: bench/pvi_core_model.sv */
// Behavioural core: stack memory, vector table, instruction completion
`timescale 1ns/1ps
`default_nettype none
module pvi_core_model (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        hold_i,
   input  wire logic        do_ret_i,
   input  wire logic [15:0] pc_new_i,
   input  wire logic        pc_load_i,
   input  wire logic        sp_dec_i,
   input  wire logic        sp_inc_i,
   input  wire logic        stk_we_i,
   input  wire logic        stk_rd_i,
   input  wire logic [7:0]  stk_addr_i,
   input  wire logic [7:0]  stk_wdata_i,
   input  wire logic        vec_rd_i,
   input  wire logic [15:0] vec_addr_i,
   output logic             instr_done_o,
   output logic             ret_o,
   output logic [15:0]      pc_o,
   output logic [7:0]       sp_o,
   output logic [7:0]       stk_rdata_o,
   output logic [7:0]       vec_data_o
);
   logic [7:0]  mem [256];
   logic [15:0] last_pc;
   logic [1:0]  cnt;
   // =====================================================
   // Buses
   // Released lines show the inverse, never a stale value
   assign stk_rdata_o = stk_rd_i ? mem[stk_addr_i] : ~mem[stk_addr_i];
   assign vec_data_o = vec_addr_i[7:0] ^ (vec_rd_i ? 8'h3c : 8'hc3);
   // =====================================================
   // Instruction flow
   assign instr_done_o = (cnt == 2'd2) && !hold_i;
   assign ret_o = do_ret_i;
   always @(posedge clk_i) begin
      cnt <= rst_i ? 2'd0 : cnt + 2'd1;
      if (stk_we_i) mem[stk_addr_i] <= stk_wdata_i;
      if (rst_i) sp_o <= 8'hff;
      else sp_o <= sp_o - {7'd0, sp_dec_i} + {7'd0, sp_inc_i};
      if (rst_i) pc_o <= 16'h0000;
      else if (pc_load_i) pc_o <= pc_new_i;
      else if (instr_done_o) begin
         last_pc <= pc_o;
         pc_o <= pc_o + 16'h0001;
      end
   end
endmodule
`default_nettype wire

/* File: core/pvi_irq_unit.sv */
// Prioritized vectored interrupt unit with Wishbone register port
//
// Summary of operation
// - Each external pin requests on falling, rising or both edges.
// - Pin edges latch into request flags; vectoring clears them.
// - Timer match events set the four timer request flags.
// - Conversion completion sets the converter request flag.
// - Watchdog match sets its flag only when reset-select is 0.
// - Interval counter overflow sets the interval request flag.
// - Source acceptance needs request, enable and master flag bit 2.
// - A source with enable zero is never accepted.
// - Fixed priority ext0 highest down to serial lowest.
// - Vector is FFFA minus two per priority step; reset FFFE.
// - First acceptance step clears the master enable flag.
// - Acceptance clears the accepted source's request flag.
// - Push return address and status word; three stack decrements.
// - Acceptance takes eight clocks, after the instruction ends.
// - Requests stay latched until accepted or cleared.
// - Return instruction restores status word and program counter.
// - Master flag clear blocks all maskable requests.
// - Request flags are readable and writable by software.
// - Only program counter and status word are saved by hardware.
// - Any acceptance blocks the next interrupt for one instruction.
// - Edge choices live in the edge selection register at 0E6.
// - Simultaneous requests resolve to the higher priority.
`timescale 1ns/1ps
`default_nettype none
`include "pvi_regs.svh"
module pvi_irq_unit #(
   parameter int          N_EXT      = 4,
   parameter logic [15:0] BRK_VECTOR = 16'hffde
) (
   input  wire logic                  clk_i,
   input  wire logic                  rst_i,
   input  wire logic                  wb_cyc_i,
   input  wire logic                  wb_stb_i,
   input  wire logic                  wb_we_i,
   input  wire logic [9:2]            wb_adr_i,
   input  wire logic [3:0]            wb_sel_i,
   input  wire logic [31:0]           wb_dat_i,
   output logic      [31:0]           wb_dat_o,
   output logic                       wb_ack_o,
   input  wire logic [3:0]            ext_irq_pin_i,
   input  wire logic [3:0]            timer_match_i,
   input  wire logic                  conv_done_i,
   input  wire logic                  watchdog_match_i,
   input  wire logic                  interval_ovf_i,
   input  wire logic                  serial_req_i,
   output logic                       watchdog_reset_o,
   input  wire logic                  instr_done_i,
   input  wire logic                  irq_return_instr_i,
   input  wire logic                  irq_enable_instr_i,
   input  wire logic                  irq_disable_instr_i,
   input  wire logic                  software_break_i,
   input  wire logic [15:0]           pc_i,
   input  wire logic [7:0]            sp_i,
   output logic                       hold_o,
   output logic      [15:0]           pc_o,
   output logic                       pc_load_o,
   output logic                       sp_dec_o,
   output logic                       sp_inc_o,
   output logic                       stk_we_o,
   output logic                       stk_rd_o,
   output logic      [7:0]            stk_addr_o,
   output logic      [7:0]            stk_wdata_o,
   input  wire logic [7:0]            stk_rdata_i,
   output logic                       vec_rd_o,
   output logic      [15:0]           vec_addr_o,
   input  wire logic [7:0]            vec_data_i,
   output logic      [7:0]            status_o
);
   import pvi_pkg::*;

   if (N_EXT != 4) begin : g_bad_ext
      $error("pvi_irq_unit serves exactly four external pins");
   end

   // ==========================================================
   // Helpers
   function automatic logic [3:0] first_set(input pvi_src_t v);
      logic [3:0] idx;
      idx = 4'h0;
      for (int i = 11; i >= 0; i--) begin
         if (v[i]) begin
            idx = 4'(i);
         end
      end
      return idx;
   endfunction

   function automatic logic [7:0] rev8(input logic [7:0] v);
      logic [7:0] r;
      r = 8'h00;
      for (int i = 0; i < 8; i++) begin
         r[i] = v[7 - i];
      end
      return r;
   endfunction

   // ==========================================================
   // State
   logic [3:0]  s1, s2, s3, lvl;
   logic [3:0]  next_lvl;
   pvi_src_t    req, en, next_req, next_en;
   logic [7:0]  edge_sel, next_edge_sel;
   logic [7:0]  psw, next_psw;
   logic        wd_sel, next_wd_sel;
   logic        ack, next_ack;
   logic [31:0] rdata, next_rdata;
   pvi_state_e  state, next_state;
   logic [15:0] vec, next_vec, pc_q, next_pc;
   logic [7:0]  sp_q, next_sp;
   logic [3:0]  acc_idx, next_idx;
   logic        acc_brk, next_brk, block, next_block;
   logic [3:0]  ext_ev;
   pvi_src_t    set_ev, pend;
   logic        wb_req, wb_wr;

   assign wb_req = wb_cyc_i & wb_stb_i;
   // Writes commit on the edge where the master sees ack
   assign wb_wr  = wb_req & wb_we_i & ack & wb_sel_i[0];
   assign pend   = req & en;

   // ==========================================================
   // Pin synchronisers and edge detect
   always_comb begin
      next_lvl = lvl;
      for (int i = 0; i < 4; i++) begin
         if (s2[i] == s3[i]) begin
            next_lvl[i] = s3[i];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s1  <= 4'h0;
         s2  <= 4'h0;
         s3  <= 4'h0;
         lvl <= 4'h0;
      end else begin
         s1  <= ext_irq_pin_i;
         s2  <= s1;
         s3  <= s2;
         lvl <= next_lvl;
      end
   end

   // Edge select: bit 2i+1 rising, bit 2i falling
   for (genvar g = 0; g < 4; g++) begin : g_edge
      assign ext_ev[g] = (s2[g] == s3[g]) && (s3[g] != lvl[g]) &&
                         (s3[g] ? edge_sel[2*g+1] : edge_sel[2*g]);
   end

   // ==========================================================
   // Request sources in priority order
   always_comb begin
      set_ev     = '0;
      set_ev[0]  = ext_ev[0];
      set_ev[1]  = ext_ev[1];
      set_ev[2]  = timer_match_i[0];
      set_ev[3]  = timer_match_i[1];
      set_ev[4]  = ext_ev[2];
      set_ev[5]  = ext_ev[3];
      set_ev[6]  = timer_match_i[2];
      set_ev[7]  = timer_match_i[3];
      set_ev[8]  = conv_done_i;
      set_ev[9]  = watchdog_match_i & ~wd_sel;
      set_ev[10] = interval_ovf_i;
      set_ev[11] = serial_req_i;
   end

   assign watchdog_reset_o = watchdog_match_i & wd_sel;

   // ==========================================================
   // Register file
   always_comb begin
      next_req      = req;
      next_en       = en;
      next_edge_sel = edge_sel;
      next_psw      = psw;
      next_wd_sel   = wd_sel;
      if (wb_wr) begin
         if (wb_adr_i == `PVI_IDX_EN_HIGH) begin
            next_en[7:0] = rev8(wb_dat_i[7:0]);
         end else if (wb_adr_i == `PVI_IDX_EN_LOW) begin
            next_en[11:8] = {wb_dat_i[4], wb_dat_i[5], wb_dat_i[6],
                             wb_dat_i[7]};
         end else if (wb_adr_i == `PVI_IDX_REQ_HIGH) begin
            next_req[7:0] = rev8(wb_dat_i[7:0]);
         end else if (wb_adr_i == `PVI_IDX_REQ_LOW) begin
            next_req[11:8] = {wb_dat_i[4], wb_dat_i[5], wb_dat_i[6],
                              wb_dat_i[7]};
         end else if (wb_adr_i == `PVI_IDX_EDGE_SEL) begin
            next_edge_sel = wb_dat_i[7:0];
         end else if (wb_adr_i == `PVI_IDX_STATUS) begin
            next_psw = wb_dat_i[7:0];
         end else if (wb_adr_i == `PVI_IDX_CTRL) begin
            next_wd_sel = wb_dat_i[`PVI_WD_SEL_BIT];
         end
      end
      if (irq_enable_instr_i) begin
         next_psw[`PVI_I_FLAG_BIT] = 1'b1;
      end else if (irq_disable_instr_i) begin
         next_psw[`PVI_I_FLAG_BIT] = 1'b0;
      end
      if (state == ST_ACC_MASK) begin
         next_psw[`PVI_I_FLAG_BIT] = 1'b0;
      end else if (state == ST_RET_PSW) begin
         next_psw = stk_rdata_i;
      end
      if (state == ST_ACC_CLR && !acc_brk) begin
         next_req[acc_idx] = 1'b0;
      end
      // Flags otherwise hold until accepted or written
      next_req = next_req | set_ev;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         req      <= '0;
         en       <= '0;
         edge_sel <= `PVI_RST_BYTE;
         psw      <= `PVI_RST_BYTE;
         wd_sel   <= 1'b0;
      end else begin
         req      <= next_req;
         en       <= next_en;
         edge_sel <= next_edge_sel;
         psw      <= next_psw;
         wd_sel   <= next_wd_sel;
      end
   end

   // ==========================================================
   // Wishbone read side; unmapped reads return zero
   always_comb begin
      next_ack   = wb_req & ~ack;
      next_rdata = rdata;
      if (wb_req && !ack) begin
         next_rdata = 32'h0000_0000;
         if (wb_adr_i == `PVI_IDX_EN_HIGH) begin
            next_rdata[7:0] = rev8(en[7:0]);
         end else if (wb_adr_i == `PVI_IDX_EN_LOW) begin
            next_rdata[7:0] = {en[8], en[9], en[10], en[11], 4'h0};
         end else if (wb_adr_i == `PVI_IDX_REQ_HIGH) begin
            next_rdata[7:0] = rev8(req[7:0]);
         end else if (wb_adr_i == `PVI_IDX_REQ_LOW) begin
            next_rdata[7:0] = {req[8], req[9], req[10], req[11], 4'h0};
         end else if (wb_adr_i == `PVI_IDX_EDGE_SEL) begin
            next_rdata[7:0] = edge_sel;
         end else if (wb_adr_i == `PVI_IDX_STATUS) begin
            next_rdata[7:0] = psw;
         end else if (wb_adr_i == `PVI_IDX_CTRL) begin
            next_rdata[`PVI_WD_SEL_BIT] = wd_sel;
         end else if (wb_adr_i == `PVI_IDX_STATE) begin
            next_rdata[15:0] = {state[11:0], acc_idx};
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack   <= 1'b0;
         rdata <= 32'h0000_0000;
      end else begin
         ack   <= next_ack;
         rdata <= next_rdata;
      end
   end

   assign wb_ack_o = ack;
   assign wb_dat_o = rdata;

   // ==========================================================
   // Acceptance and return sequencer
   always_comb begin
      next_state = state;
      next_vec   = vec;
      next_pc    = pc_q;
      next_sp    = sp_q;
      next_idx   = acc_idx;
      next_brk   = acc_brk;
      next_block = block;
      case (state)
         ST_IDLE: begin
            if (instr_done_i) begin
               next_block = 1'b0;
               if (irq_return_instr_i) begin
                  next_sp    = sp_i;
                  next_state = ST_RET_PSW;
               end else if (block) begin
                  next_state = ST_IDLE;
               end else if (psw[`PVI_I_FLAG_BIT] && |pend) begin
                  next_idx   = first_set(pend);
                  next_brk   = 1'b0;
                  next_vec   = `PVI_VEC_TOP -
                               {11'h000, first_set(pend), 1'b0};
                  next_sp    = sp_i;
                  next_pc    = pc_i;
                  next_state = ST_ACC_MASK;
               end else if (software_break_i) begin
                  next_brk   = 1'b1;
                  next_vec   = BRK_VECTOR;
                  next_sp    = sp_i;
                  next_pc    = pc_i;
                  next_state = ST_ACC_MASK;
               end
            end
         end
         ST_ACC_MASK: next_state = ST_ACC_CLR;
         ST_ACC_CLR:  next_state = ST_PUSH_PCH;
         ST_PUSH_PCH: next_state = ST_PUSH_PCL;
         ST_PUSH_PCL: next_state = ST_PUSH_PSW;
         ST_PUSH_PSW: next_state = ST_VEC_LO;
         ST_VEC_LO: begin
            next_pc[7:0] = vec_data_i;
            next_state   = ST_VEC_HI;
         end
         ST_VEC_HI: begin
            next_pc[15:8] = vec_data_i;
            next_state    = ST_ACC_LOAD;
         end
         ST_ACC_LOAD: begin
            next_block = 1'b1;
            next_state = ST_IDLE;
         end
         ST_RET_PSW: next_state = ST_RET_PCL;
         ST_RET_PCL: begin
            next_pc[7:0] = stk_rdata_i;
            next_state   = ST_RET_PCH;
         end
         ST_RET_PCH: begin
            next_pc[15:8] = stk_rdata_i;
            next_state    = ST_ACC_LOAD;
         end
         default: next_state = ST_IDLE;
      endcase
   end

   // Reset enters the vector fetch directly, bypassing the gating
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state   <= ST_VEC_LO;
         vec     <= `PVI_VEC_RESET;
         pc_q    <= 16'h0000;
         sp_q    <= 8'h00;
         acc_idx <= 4'h0;
         acc_brk <= 1'b0;
         block   <= 1'b0;
      end else begin
         state   <= next_state;
         vec     <= next_vec;
         pc_q    <= next_pc;
         sp_q    <= next_sp;
         acc_idx <= next_idx;
         acc_brk <= next_brk;
         block   <= next_block;
      end
   end

   // ==========================================================
   // Core-facing strobes; only PC and status word are stacked
   always_comb begin
      stk_addr_o  = 8'h00;
      stk_wdata_o = 8'h00;
      case (state)
         ST_PUSH_PCH: begin
            stk_addr_o  = sp_q;
            stk_wdata_o = pc_q[15:8];
         end
         ST_PUSH_PCL: begin
            stk_addr_o  = 8'(sp_q - 8'h01);
            stk_wdata_o = pc_q[7:0];
         end
         ST_PUSH_PSW: begin
            stk_addr_o  = 8'(sp_q - 8'h02);
            stk_wdata_o = psw;
         end
         ST_RET_PSW: stk_addr_o = 8'(sp_q + 8'h01);
         ST_RET_PCL: stk_addr_o = 8'(sp_q + 8'h02);
         ST_RET_PCH: stk_addr_o = 8'(sp_q + 8'h03);
         default:    stk_addr_o = 8'h00;
      endcase
   end

   assign stk_we_o   = (state == ST_PUSH_PCH) | (state == ST_PUSH_PCL) |
                       (state == ST_PUSH_PSW);
   assign sp_dec_o   = stk_we_o;
   assign stk_rd_o   = (state == ST_RET_PSW) | (state == ST_RET_PCL) |
                       (state == ST_RET_PCH);
   assign sp_inc_o   = stk_rd_o;
   assign vec_rd_o   = (state == ST_VEC_LO) | (state == ST_VEC_HI);
   assign vec_addr_o = (state == ST_VEC_HI) ? 16'(vec + 16'h0001) : vec;
   assign pc_load_o  = (state == ST_ACC_LOAD);
   assign pc_o       = pc_q;
   assign hold_o     = (state != ST_IDLE);
   assign status_o   = psw;

   // ==========================================================
   // Assertions
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   sequence acc_steps;
      state == ST_ACC_CLR ##1 state == ST_PUSH_PCH ##1
      state == ST_PUSH_PCL ##1 state == ST_PUSH_PSW ##1
      state == ST_VEC_LO ##1 state == ST_VEC_HI ##1
      state == ST_ACC_LOAD;
   endsequence

   sequence ret_steps;
      state == ST_RET_PCL ##1 state == ST_RET_PCH ##1
      state == ST_ACC_LOAD;
   endsequence

   a_accept_length: assert property (
      state == ST_ACC_MASK |=> acc_steps ##1 state == ST_IDLE)
      else $error("acceptance is not eight cycles");
   a_master_cleared: assert property (
      state == ST_ACC_MASK && !irq_enable_instr_i |=>
      !psw[`PVI_I_FLAG_BIT])
      else $error("master flag not cleared on acceptance");
   a_three_pushes: assert property (
      state == ST_ACC_MASK |-> ##2 (stk_we_o && sp_dec_o) [*3] ##1 !stk_we_o)
      else $error("stack not pushed three times");
   a_gated_accept: assert property (
      state == ST_ACC_MASK && !acc_brk |->
      $past(psw[`PVI_I_FLAG_BIT]) &&
      (($past(pend) >> acc_idx) & 12'h001) == 12'h001)
      else $error("ungated source accepted");
   a_masked_idle: assert property (
      state == ST_IDLE && !psw[`PVI_I_FLAG_BIT] && !software_break_i |=>
      state != ST_ACC_MASK)
      else $error("accepted while master flag clear");
   a_priority_pick: assert property (
      state == ST_ACC_MASK && !acc_brk |->
      ($past(pend) & ((12'h001 << acc_idx) - 12'h001)) == 12'h000)
      else $error("lower priority source picked");
   a_vector_addr: assert property (
      state == ST_ACC_MASK && !acc_brk |-> ##5
      vec_addr_o == 16'(16'hfffa - {11'h000, acc_idx, 1'b0}))
      else $error("wrong vector address");
   a_flag_clear: assert property (
      state == ST_ACC_CLR && !acc_brk && !set_ev[acc_idx] |=>
      !req[acc_idx])
      else $error("accepted flag not cleared");
   a_set_wins: assert property (
      |set_ev |=> (req & $past(set_ev)) == $past(set_ev))
      else $error("hardware set lost");
   a_return_seq: assert property (
      state == ST_RET_PSW |=> ret_steps ##0 pc_load_o)
      else $error("return sequence broken");
   a_block_next: assert property (
      state == ST_ACC_LOAD |=> (state != ST_ACC_MASK) [*2])
      else $error("acceptance right after acceptance");
   a_wd_gated: assert property (
      watchdog_match_i && wd_sel && !req[9] && !wb_wr |=> !req[9])
      else $error("watchdog flag set in reset mode");
endmodule
`default_nettype wire

/* File: core/pvi_pkg.sv */
// Types shared by the interrupt unit
package pvi_pkg;
   typedef enum logic [11:0] {
      ST_IDLE     = 12'h001,
      ST_ACC_MASK = 12'h002,
      ST_ACC_CLR  = 12'h004,
      ST_PUSH_PCH = 12'h008,
      ST_PUSH_PCL = 12'h010,
      ST_PUSH_PSW = 12'h020,
      ST_VEC_LO   = 12'h040,
      ST_VEC_HI   = 12'h080,
      ST_ACC_LOAD = 12'h100,
      ST_RET_PSW  = 12'h200,
      ST_RET_PCL  = 12'h400,
      ST_RET_PCH  = 12'h800
   } pvi_state_e;
   typedef logic [11:0] pvi_src_t;
endpackage

/* File: core/pvi_regs.svh */
// Register indices, field positions, reset values and timing counts
`ifndef PVI_REGS_SVH
`define PVI_REGS_SVH
// ==========================================================
// Register indices (byte address = index * 4)
`define PVI_IDX_EN_HIGH   8'he2
`define PVI_IDX_EN_LOW    8'he3
`define PVI_IDX_REQ_HIGH  8'he4
`define PVI_IDX_REQ_LOW   8'he5
`define PVI_IDX_EDGE_SEL  8'he6
`define PVI_IDX_STATUS    8'he7
`define PVI_IDX_CTRL      8'he8
`define PVI_IDX_STATE     8'he9
// ==========================================================
// Fields and reset values
`define PVI_I_FLAG_BIT    2
`define PVI_WD_SEL_BIT    0
`define PVI_RST_BYTE      8'h00
// ==========================================================
// Vectors and timing
`define PVI_VEC_TOP       16'hfffa
`define PVI_VEC_RESET     16'hfffe
`define PVI_ACC_OSC_CLKS  8
`define PVI_CLKS_PER_OSC  1
`define PVI_ACC_CYCLES    (`PVI_ACC_OSC_CLKS * `PVI_CLKS_PER_OSC)
`endif
